// ---- rtl/msc_defs.vh ----
// Constants for the memory scan address control block
`ifndef MSC_DEFS_VH
`define MSC_DEFS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define MSC_ADDR_CTRL     8'h00
`define MSC_ADDR_CUR_HI   8'h04
`define MSC_ADDR_CUR_LO   8'h08
`define MSC_ADDR_END_HI   8'h0C
`define MSC_ADDR_END_LO   8'h10
`define MSC_ADDR_IRQ_STAT 8'h14
`define MSC_ADDR_IRQ_MASK 8'h18

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define MSC_CTRL_EN    7
`define MSC_CTRL_GO    6
`define MSC_CTRL_BUSY  5
`define MSC_CTRL_INVAL 4
`define MSC_CTRL_INTERRUPT_MANAGE_SELECT  3
`define MSC_CTRL_RESET 8'h00
`define MSC_ADDR_RESET 16'h0000
`define MSC_END_RESET  16'h0000

// ----------------------------------------------------------------------
// Access modes
// ----------------------------------------------------------------------
`define MSC_MODE_CONC  2'b00
`define MSC_MODE_BURST 2'b01
`define MSC_MODE_PEEK  2'b10
`define MSC_MODE_TRIG  2'b11

// ----------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------
`define MSC_IRQ_DONE  0
`define MSC_IRQ_INVAL 1
`define MSC_IRQ_WORD  2

// ----------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------
`define MSC_RESP_OKAY   2'b00
`define MSC_RESP_SLVERR 2'b10

`endif

// ---- rtl/msc_sync2.v ----
// Two-flop synchroniser for a single level
`timescale 1ns/1ps
module msc_sync2 (
	input  wire clk_i,
	input  wire rstn_i,
	input  wire d_i,
	output wire q_o
);
	reg meta_q;
	reg sync_q;

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule // msc_sync2

// ---- rtl/msc_irq.v ----
// Sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/1ps
module msc_irq (
	input  wire       clk_i,
	input  wire       rstn_i,
	input  wire [2:0] event_i,
	input  wire [2:0] clear_i,
	input  wire       mask_we_i,
	input  wire [2:0] mask_wdata_i,
	output wire [2:0] status_o,
	output wire [2:0] mask_o,
	output wire       irq_o
);
	reg [2:0] status_q;
	reg [2:0] mask_q;

	// ------------------------------------------------------------------
	// Status and mask
	// ------------------------------------------------------------------
	// Set beats clear so an event in the clearing cycle is kept
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			status_q <= 3'h0;
			mask_q   <= 3'h0;
		end else begin
			status_q <= (status_q & ~clear_i) | event_i;
			if (mask_we_i) begin
				mask_q <= mask_wdata_i;
			end
		end
	end

	assign status_o = status_q;
	assign mask_o   = mask_q;
	assign irq_o    = |(status_q & mask_q);
endmodule // msc_irq

// ---- rtl/msc_top.v ----
// Memory scan address control with AXI4-Lite registers
// What this block does
// - Keeps 16-bit current address in two bytes, increments after each fetch
// - Flags address invalid once scanning passes the last memory word
// - Ignores writes to either current address byte while go reads one
// - Clears go when current passes end address and no cycle is running
// - Busy reads one during a scanner cycle, zero otherwise
// - Mode 10 peek, 01 burst, 00 concurrent; burst stalls the processor
// - Interrupt manage bit masks go during interrupts, resumes afterwards
// - Concurrent or triggered without manage bit keeps fetching in interrupts
`timescale 1ns/1ps
`include "msc_defs.vh"
module msc_top (
	input  wire        clk_i,
	input  wire        rstn_i,
	// AXI4-Lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// Processor interrupt state and stall
	input  wire        cpu_in_irq_i,
	output wire        cpu_stall_o,
	// Memory read port, one-cycle latency
	output wire        mem_rd_o,
	output wire [15:0] mem_addr_o,
	input  wire [13:0] mem_rdata_i,
	// Checksum client
	input  wire        client_ready_i,
	output wire        client_valid_o,
	output wire [13:0] client_data_o,
	// Interrupt
	output wire        irq_o
);
	// ------------------------------------------------------------------
	// State machine
	// ------------------------------------------------------------------
	localparam [1:0] ST_IDLE  = 2'd0;
	localparam [1:0] ST_FETCH = 2'd1;
	localparam [1:0] ST_SEND  = 2'd2;

	// Limit is one past 0x3FFF, the last valid word
	localparam [15:0] MEM_WORDS = 16'h4000;

	reg        en_q;
	reg        go_q;
	reg        interrupt_manage_select_q;
	reg [1:0]  mode_q;
	reg [15:0] cur_q;
	reg [15:0] end_q;
	reg [1:0]  st_q;
	reg [13:0] data_q;
	reg        valid_q;

	reg        aw_got_q;
	reg        w_got_q;
	reg [7:0]  aw_q;
	reg [31:0] w_q;
	reg [3:0]  ws_q;
	reg        bvalid_q;
	reg [1:0]  bresp_q;
	reg        rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0]  rresp_q;

	wire       in_irq;
	wire [2:0] irq_stat;
	wire [2:0] irq_mask;
	wire       do_write;
	wire       wr_lane0;
	wire       irq_clr_we;
	wire       irq_mask_we;
	wire       ctrl_we;
	wire       cur_hi_we;
	wire       cur_lo_we;
	wire       end_hi_we;
	wire       end_lo_we;

	reg [1:0]  st_d;
	reg [31:0] rdata_d;
	reg [1:0]  rresp_d;

	function is_mapped;
		input [7:0] a;
		begin
			is_mapped = (a == `MSC_ADDR_CTRL) || (a == `MSC_ADDR_CUR_HI) ||
				(a == `MSC_ADDR_CUR_LO) || (a == `MSC_ADDR_END_HI) ||
				(a == `MSC_ADDR_END_LO) || (a == `MSC_ADDR_IRQ_STAT) ||
				(a == `MSC_ADDR_IRQ_MASK);
		end
	endfunction

	msc_sync2 u_irq_sync (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.d_i    (cpu_in_irq_i),
		.q_o    (in_irq)
	);

	// ------------------------------------------------------------------
	// Effective go and fetch conditions
	// ------------------------------------------------------------------
	// Manage bit suppresses go in interrupts, stored bit is untouched
	wire go_eff = en_q && go_q && !(interrupt_manage_select_q && in_irq);
	wire past_end = cur_q > end_q;
	wire invalid = cur_q >= MEM_WORDS;
	wire busy = (st_q != ST_IDLE);
	wire start = go_eff && (st_q == ST_IDLE) && !past_end && !invalid &&
		client_ready_i && !valid_q;
	wire done_evt = go_q && !busy && (past_end || invalid);

	assign mem_rd_o   = start;
	assign mem_addr_o = cur_q;
	assign client_valid_o = valid_q;
	assign client_data_o  = data_q;
	// Burst holds the processor for the whole scan; peek stalls per fetch
	assign cpu_stall_o = en_q && go_q && !(interrupt_manage_select_q && in_irq) &&
		((mode_q == `MSC_MODE_BURST) ||
		((mode_q == `MSC_MODE_PEEK) && busy));

	// ------------------------------------------------------------------
	// AXI write path
	// ------------------------------------------------------------------
	assign s_axi_awready = !aw_got_q && !bvalid_q;
	assign s_axi_wready  = !w_got_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign do_write = aw_got_q && w_got_q && !bvalid_q;
	assign wr_lane0 = do_write && ws_q[0] && is_mapped(aw_q);
	assign irq_clr_we  = wr_lane0 && (aw_q == `MSC_ADDR_IRQ_STAT);
	assign irq_mask_we = wr_lane0 && (aw_q == `MSC_ADDR_IRQ_MASK);
	assign ctrl_we     = wr_lane0 && (aw_q == `MSC_ADDR_CTRL);
	// Current address is locked while go reads one
	assign cur_hi_we   = wr_lane0 && !go_q &&
		(aw_q == `MSC_ADDR_CUR_HI);
	assign cur_lo_we   = wr_lane0 && !go_q &&
		(aw_q == `MSC_ADDR_CUR_LO);
	assign end_hi_we   = wr_lane0 && (aw_q == `MSC_ADDR_END_HI);
	assign end_lo_we   = wr_lane0 && (aw_q == `MSC_ADDR_END_LO);

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			aw_q     <= 8'h00;
			w_q      <= 32'h0000_0000;
			ws_q     <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= `MSC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				aw_q     <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				w_q     <= s_axi_wdata;
				ws_q    <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= is_mapped(aw_q) ? `MSC_RESP_OKAY :
					`MSC_RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			en_q   <= 1'b0;
			go_q   <= 1'b0;
			interrupt_manage_select_q <= 1'b0;
			mode_q <= `MSC_MODE_CONC;
		end else begin
			if (ctrl_we) begin
				en_q   <= w_q[`MSC_CTRL_EN];
				go_q   <= w_q[`MSC_CTRL_GO];
				interrupt_manage_select_q <= w_q[`MSC_CTRL_INTERRUPT_MANAGE_SELECT];
				mode_q <= w_q[1:0];
			end
			// Hardware clear is the only way go falls on its own
			if (done_evt) begin
				go_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Current and end address
	// ------------------------------------------------------------------
	// Loads and fetches never meet: loads need go low, fetches need it high
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cur_q <= `MSC_ADDR_RESET;
			end_q <= `MSC_END_RESET;
		end else begin
			if (cur_hi_we) begin
				cur_q[15:8] <= w_q[7:0];
			end
			if (cur_lo_we) begin
				cur_q[7:0] <= w_q[7:0];
			end
			if (start) begin
				cur_q <= cur_q + 16'h0001;
			end
			if (end_hi_we) begin
				end_q[15:8] <= w_q[7:0];
			end
			if (end_lo_we) begin
				end_q[7:0] <= w_q[7:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Scanner state machine
	// ------------------------------------------------------------------
	always @* begin
		st_d = st_q;
		case (st_q)
		ST_IDLE: begin
			if (start) begin
				st_d = ST_FETCH;
			end
		end
		ST_FETCH: begin
			st_d = ST_SEND;
		end
		ST_SEND: begin
			if (!valid_q || client_ready_i) begin
				st_d = ST_IDLE;
			end
		end
		default: begin
			st_d = ST_IDLE;
		end
		endcase
		// Disable drops any half-done cycle but keeps the registers
		if (!en_q) begin
			st_d = ST_IDLE;
		end
	end

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q    <= ST_IDLE;
			data_q  <= 14'h0000;
			valid_q <= 1'b0;
		end else begin
			st_q <= st_d;
			if (!en_q) begin
				valid_q <= 1'b0;
			end else if (st_q == ST_FETCH) begin
				data_q  <= mem_rdata_i;
				valid_q <= 1'b1;
			end else if (valid_q && client_ready_i) begin
				valid_q <= 1'b0;
			end
		end
	end

	msc_irq u_irq (
		.clk_i        (clk_i),
		.rstn_i       (rstn_i),
		.event_i      ({(st_q == ST_FETCH), invalid && go_q, done_evt}),
		.clear_i      (irq_clr_we ? w_q[2:0] : 3'h0),
		.mask_we_i    (irq_mask_we),
		.mask_wdata_i (w_q[2:0]),
		.status_o     (irq_stat),
		.mask_o       (irq_mask),
		.irq_o        (irq_o)
	);

	// ------------------------------------------------------------------
	// AXI read path
	// ------------------------------------------------------------------
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// Unmapped reads return zero with an error response
	always @* begin
		rresp_d = is_mapped(s_axi_araddr) ? `MSC_RESP_OKAY :
			`MSC_RESP_SLVERR;
		case (s_axi_araddr)
		`MSC_ADDR_CTRL: begin
			rdata_d = {24'h00_0000, en_q, go_q, busy, invalid,
				interrupt_manage_select_q, 1'b0, mode_q};
		end
		`MSC_ADDR_CUR_HI: begin
			rdata_d = {24'h00_0000, cur_q[15:8]};
		end
		`MSC_ADDR_CUR_LO: begin
			rdata_d = {24'h00_0000, cur_q[7:0]};
		end
		`MSC_ADDR_END_HI: begin
			rdata_d = {24'h00_0000, end_q[15:8]};
		end
		`MSC_ADDR_END_LO: begin
			rdata_d = {24'h00_0000, end_q[7:0]};
		end
		`MSC_ADDR_IRQ_STAT: begin
			rdata_d = {29'h0000_0000, irq_stat};
		end
		`MSC_ADDR_IRQ_MASK: begin
			rdata_d = {29'h0000_0000, irq_mask};
		end
		default: begin
			rdata_d = 32'h0000_0000;
		end
		endcase
	end

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `MSC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
endmodule // msc_top

// ---- testbench/msc_checker.sv ----
// Port checker for the memory scan address control block
`timescale 1ns/1ps
module msc_checker (
	input wire        clk_i,
	input wire        rstn_i,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire        mem_rd_o,
	input wire [15:0] mem_addr_o,
	input wire [13:0] mem_rdata_i,
	input wire        client_ready_i,
	input wire        client_valid_o,
	input wire [13:0] client_data_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	a_fetch_ready: assert property (
		mem_rd_o |-> client_ready_i) else $error("fetch without ready");
	a_addr_step: assert property (
		mem_rd_o |=> mem_addr_o == $past(mem_addr_o) + 16'h0001)
		else $error("address did not step");
	a_word_lat: assert property (
		mem_rd_o |-> ##2 client_valid_o) else $error("word late");
	a_word_data: assert property (
		mem_rd_o ##1 1'h1 |=> client_data_o == $past(mem_rdata_i))
		else $error("word data wrong");
	a_valid_hold: assert property (
		client_valid_o && !client_ready_i |=>
		client_valid_o && $stable(client_data_o)) else $error("word dropped");
	a_addr_range: assert property (
		mem_rd_o |-> mem_addr_o < 16'h4000) else $error("invalid fetch");
	a_one_word: assert property (
		client_valid_o |-> !mem_rd_o) else $error("fetch while pending");
	a_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	a_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule // msc_checker

bind msc_top msc_checker u_chk (.clk_i, .rstn_i, .s_axi_bvalid,
	.s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .mem_rd_o,
	.mem_addr_o, .mem_rdata_i, .client_ready_i, .client_valid_o,
	.client_data_o);

// ---- testbench/msc_client_model.sv ----
// Program memory and checksum client model
`timescale 1ns/1ps
module msc_client_model (
	input  wire        clk_i,
	input  wire        rstn_i,
	input  wire        slow_i,
	input  wire        mem_rd_i,
	input  wire [15:0] mem_addr_i,
	output reg  [13:0] mem_rdata_o,
	output reg         client_ready_o,
	input  wire        client_valid_i,
	input  wire [13:0] client_data_i,
	output reg  [15:0] word_cnt_o,
	output reg  [13:0] sum_o
);
	reg [1:0] div_q;
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_q <= 2'h0;
			mem_rdata_o <= 14'h0000;
			client_ready_o <= 1'h0;
			word_cnt_o <= 16'h0000;
			sum_o <= 14'h0000;
		end else begin
			div_q <= div_q + 2'h1;
			// Slow mode offers ready one cycle in four
			client_ready_o <= !slow_i || div_q == 2'h3;
			// Word valid one cycle only; otherwise the bus churns
			mem_rdata_o <= mem_rd_i ? mem_addr_i[13:0] ^ 14'h1A5C : ~mem_rdata_o;
			if (client_valid_i && client_ready_o) begin
				word_cnt_o <= word_cnt_o + 16'h0001;
				sum_o <= sum_o + client_data_i;
			end
		end
	end
endmodule // msc_client_model

// ---- testbench/tb.sv ----
// Self-checking testbench for the memory scan address control block
`timescale 1ns/1ps
module tb;
	logic        clk_i = 1'h0;
	logic        rstn_i = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0, cpu_in_irq_i = 1'h0;
	logic        slow = 1'h0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire         s_axi_arready, s_axi_rvalid, cpu_stall_o, irq_o;
	wire         mem_rd_o, client_ready_i, client_valid_o;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire  [15:0] mem_addr_o, word_cnt;
	wire  [13:0] mem_rdata_i, client_data_o, sum;
	logic [31:0] rv;
	logic [1:0]  rr;
	int          err_total = 0, n_compared = 0, cyc = 0;
	int          stall_cnt = 0, st0 = 0;

	msc_top u_dut (.clk_i, .rstn_i, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_in_irq_i,
		.cpu_stall_o, .mem_rd_o, .mem_addr_o, .mem_rdata_i, .client_ready_i,
		.client_valid_o, .client_data_o, .irq_o);
	msc_client_model u_cli (.clk_i, .rstn_i, .slow_i(slow),
		.mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
		.mem_rdata_o(mem_rdata_i), .client_ready_o(client_ready_i),
		.client_valid_i(client_valid_o), .client_data_i(client_data_o),
		.word_cnt_o(word_cnt), .sum_o(sum));

	// ----------------------------------------------------------
	// Clock, timeout and bus tasks
	// ----------------------------------------------------------
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cpu_stall_o)
			stall_cnt <= stall_cnt + 1;
		if (cyc == 5000) begin
			err_total = err_total + 1;
			end_sim;
		end
	end

	task chk(input [31:0] g, input [31:0] e);
		begin
			n_compared++;
			if (g !== e) begin
				err_total++;
				$display("[FAIL] %0t got %h exp %h", $time, g, e);
			end
		end
	endtask

	// Handshakes are judged at the rising edge; one idle edge between calls
	task wr(input [7:0] a, input [7:0] d);
		logic db;
		begin
			db = 1'h0;
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h00_0000, d};
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
			while (!db) begin
				@(posedge clk_i);
				if (s_axi_awvalid && s_axi_awready)
					s_axi_awvalid <= 1'h0;
				if (s_axi_wvalid && s_axi_wready)
					s_axi_wvalid <= 1'h0;
				db = s_axi_bvalid;
				rr = s_axi_bresp;
			end
			s_axi_bready <= 1'h0;
			@(posedge clk_i);
		end
	endtask

	task rd(input [7:0] a);
		logic dr;
		begin
			dr = 1'h0;
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
			while (!dr) begin
				@(posedge clk_i);
				if (s_axi_arvalid && s_axi_arready)
					s_axi_arvalid <= 1'h0;
				dr = s_axi_rvalid;
				rv = s_axi_rdata;
				rr = s_axi_rresp;
			end
			s_axi_rready <= 1'h0;
			@(posedge clk_i);
		end
	endtask

	task rdc(input [7:0] a, input [7:0] e);
		begin
			rd(a);
			chk(rv, {24'h00_0000, e});
		end
	endtask

	task set_scan(input [15:0] c, input [15:0] e, input [7:0] ctl);
		begin
			wr(8'h04, c[15:8]);
			wr(8'h08, c[7:0]);
			wr(8'h0C, e[15:8]);
			wr(8'h10, e[7:0]);
			wr(8'h00, ctl);
		end
	endtask

	task wait_done;
		int i;
		begin
			for (i = 0; i < 200; i++) begin
				rd(8'h00);
				if (rv[6] === 1'h0)
					break;
			end
			chk(rv[6], 1'h0);
		end
	endtask

	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	task t_regs;
		begin
			rdc(8'h00, 8'h00);
			rdc(8'h04, 8'h00);
			rdc(8'h08, 8'h00);
			rd(8'h1C);
			chk(rr, 2'h2);
			chk(rv, 32'h0000_0000);
			wr(8'h1C, 8'h55);
			chk(rr, 2'h2);
			wr(8'h10, 8'h5A);
			chk(rr, 2'h0);
			rdc(8'h10, 8'h5A);
			$display("t_regs done");
		end
	endtask

	task t_scan;
		logic [15:0] c0;
		logic [13:0] s0;
		begin
			c0 = word_cnt;
			s0 = sum + (14'h0002 ^ 14'h1A5C) + (14'h0003 ^ 14'h1A5C)
				+ (14'h0004 ^ 14'h1A5C) + (14'h0005 ^ 14'h1A5C);
			wr(8'h18, 8'h07);
			slow <= 1'h1;
			st0 = stall_cnt;
			set_scan(16'h0002, 16'h0005, 8'hC2);
			wr(8'h08, 8'h00);
			wait_done;
			rdc(8'h00, 8'h82);
			rdc(8'h08, 8'h06);
			chk(word_cnt - c0, 16'h0004);
			chk(sum, s0);
			chk(stall_cnt > st0, 1'h1);
			chk(irq_o, 1'h1);
			wr(8'h18, 8'h00);
			chk(irq_o, 1'h0);
			wr(8'h18, 8'h07);
			rdc(8'h14, 8'h05);
			wr(8'h14, 8'h05);
			chk(irq_o, 1'h0);
			slow <= 1'h0;
			$display("t_scan done");
		end
	endtask

	task t_inval;
		begin
			st0 = stall_cnt;
			set_scan(16'h3FFE, 16'hFFFF, 8'hC1);
			wait_done;
			chk(stall_cnt > st0, 1'h1);
			rdc(8'h00, 8'h91);
			rdc(8'h04, 8'h40);
			rdc(8'h14, 8'h07);
			wr(8'h14, 8'h07);
			$display("t_inval done");
		end
	endtask

	task t_interrupt_manage_select;
		begin
			st0 = stall_cnt;
			cpu_in_irq_i <= 1'h1;
			set_scan(16'h0010, 16'h0011, 8'hC8);
			repeat (20) @(posedge clk_i);
			rdc(8'h08, 8'h10);
			rdc(8'h00, 8'hC8);
			cpu_in_irq_i <= 1'h0;
			wait_done;
			rdc(8'h08, 8'h12);
			cpu_in_irq_i <= 1'h1;
			set_scan(16'h0020, 16'h0020, 8'hC0);
			wait_done;
			rdc(8'h08, 8'h21);
			chk(stall_cnt, st0);
			cpu_in_irq_i <= 1'h0;
			wr(8'h00, 8'h00);
			rdc(8'h08, 8'h21);
			rdc(8'h10, 8'h20);
			$display("t_interrupt_manage_select done");
		end
	endtask

	task end_sim;
		begin
			$display("compared %0d mismatches %0d", n_compared, err_total);
			if (err_total == 0 && n_compared > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask

	initial begin
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'h1;
		@(posedge clk_i);
		t_regs;
		t_scan;
		t_inval;
		t_interrupt_manage_select;
		end_sim;
	end
endmodule // tb
